// >>> verilog/uplink_cfg_pkg.sv
// Shared constants and carrier types for the uplink port interface configuration block.
package uplink_cfg_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [11:0] CTRL_IDX = 12'h056;
  localparam logic [11:0] STATUS_IDX = 12'h057;
  localparam logic [7:0] CTRL_RESET = 8'h4B;
  localparam logic [7:0] CTRL_WMASK = 8'hDB;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int BIT_CLK_MODE = 7;
  localparam int BIT_SPEED = 6;
  localparam int BIT_IN_DLY = 4;
  localparam int BIT_EG_DLY = 3;
  localparam int IFSEL_LSB = 0;
  localparam logic [1:0] IFSEL_RGMII = 2'h3;
  localparam int STS_PHY_ROLE = 0;
  localparam int STS_RGMII = 1;
  localparam int STS_GIG = 2;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CORE_CLK_NS = 10;
  localparam int MII_CLK_PERIOD_NS = 80;
  localparam int MII_HALF_CYCLES = MII_CLK_PERIOD_NS / (2 * CORE_CLK_NS);

  // ******************************************************************
  // Carrier types
  // ******************************************************************
  typedef struct packed {
    logic rgmii;
    logic gig;
    logic phy_role;
  } cfg_t;

  typedef struct packed {
    logic en;
    logic err;
    logic [3:0] data;
  } nibble_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } frame_t;

endpackage

// >>> verilog/uplink_nibble_path.sv
// Link-clock data path of the uplink port: nibble and double-edge transfer in both directions.
`timescale 1ns/10ps
`default_nettype none

module uplink_nibble_path (
  // Link clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  input wire uplink_cfg_pkg::cfg_t i_cfg,
  // Pins from the partner
  input wire uplink_cfg_pkg::nibble_t i_pin,
  input wire logic i_pin_col,
  input wire logic i_pin_crs,
  // Frames from the switch
  input wire uplink_cfg_pkg::frame_t i_frame_tx,
  input wire logic i_frame_col,
  input wire logic i_frame_crs,
  // Pins toward the partner
  output uplink_cfg_pkg::nibble_t o_pin_rise,
  output uplink_cfg_pkg::nibble_t o_pin_fall,
  output logic o_col,
  output logic o_crs,
  // Frames toward the switch
  output uplink_cfg_pkg::frame_t o_frame_rx,
  output logic o_link_col,
  output logic o_link_crs
);

  uplink_cfg_pkg::nibble_t rise_in_r;
  uplink_cfg_pkg::nibble_t fall_in_r;
  logic col_meta_r;
  logic crs_meta_r;
  logic phy_mii;

  assign phy_mii = i_cfg.phy_role && !i_cfg.rgmii;

  // ******************************************************************
  // Ingress capture
  // ******************************************************************
  // The falling-edge flop holds the upper nibble of a double-edge byte.
  always_ff @(posedge i_clk)
  begin
    rise_in_r <= i_pin;
  end

  always_ff @(negedge i_clk)
  begin
    fall_in_r <= i_pin;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_frame_rx <= '0;
    else if (i_cfg.gig)
      o_frame_rx <= {rise_in_r.en, rise_in_r.en ^ fall_in_r.en, fall_in_r.data, rise_in_r.data}; // R14
    else
      o_frame_rx <= {rise_in_r.en, rise_in_r.err, 4'h0, rise_in_r.data}; // R9 R10
  end

  // ******************************************************************
  // Egress drive
  // ******************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pin_rise <= '0;
      o_pin_fall <= '0;
    end
    else
    begin
      o_pin_rise <= {i_frame_tx.valid, i_frame_tx.err, i_frame_tx.data[3:0]}; // R7 R8 R10
      if (i_cfg.gig)
        o_pin_fall <= {i_frame_tx.valid ^ i_frame_tx.err, 1'b0, i_frame_tx.data[7:4]}; // R14
      else
        o_pin_fall <= {i_frame_tx.valid, i_frame_tx.err, i_frame_tx.data[3:0]};
    end
  end

  // ******************************************************************
  // Media status
  // ******************************************************************
  // Collision is only meaningful while the partner MAC is sending.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !phy_mii)
    begin
      o_col <= 1'b0;
      o_crs <= 1'b0;
    end
    else
    begin
      o_col <= i_frame_col && rise_in_r.en; // R11
      o_crs <= i_frame_crs || rise_in_r.en || i_frame_tx.valid; // R7
    end
  end

  // Status from an external PHY is asynchronous to this clock.
  always_ff @(posedge i_clk)
  begin
    col_meta_r <= i_pin_col;
    crs_meta_r <= i_pin_crs;
    o_link_col <= col_meta_r; // R8
    o_link_crs <= crs_meta_r;
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  chk_nibble_ingress: assert property (!i_cfg.gig ##1 !i_cfg.gig |=> // R9
    o_frame_rx.data == {4'h0, $past(i_pin.data, 2)} && o_frame_rx.valid == $past(i_pin.en, 2))
    else $error("nibble ingress path mismatch");
  chk_ddr_ingress: assert property (i_cfg.gig ##1 i_cfg.gig |=> // R14
    o_frame_rx.data[3:0] == $past(i_pin.data, 2) && o_frame_rx.valid == $past(i_pin.en, 2))
    else $error("double-edge ingress low nibble mismatch");
  chk_collision_out: assert property (phy_mii && i_pin.en ##1 phy_mii && i_frame_col |=> o_col) // R11
    else $error("collision not signalled during transmission");
  chk_error_egress: assert property (i_frame_tx.err |=> o_pin_rise.err) // R10
    else $error("transmit error not carried to pins");
  cov_gig_frame: cover property (i_cfg.gig && i_pin.en [*4]);
  cov_phy_collision: cover property (o_col);

endmodule
`default_nettype wire

// >>> verilog/uplink_port_cfg.sv
// Uplink port interface configuration: control register, straps, pin directions and link crossing.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// R1: Ingress delay bit set adds receive clock delay; clear omits it; resets to 0.
// R2: Egress delay bit set delays forwarded clock; clear leaves it undelayed; resets to 1.
// R3: Partner sets each clock direction opposite to ours: 11 pairs 00, 01 pairs 10.
// R4: Interface select strap or field equal to 11 selects reduced-gigabit mode, the default.
// R5: Speed bit from strap or register: 1 gives gigabit, 0 gives 10/100; the code gives gigabit only while the interface select field is 11.
// R6: In nibble mode the sampled role strap picks PHY role or MAC role.
// R7: PHY role takes transmit pins in, drives clocks, collision, carrier and receive pins.
// R8: MAC role drives receive pins, accepts clocks, collision, carrier and transmit-side inputs.
// R9: Nibble paths carry four bits per clock; clock is a quarter of bit rate.
// R10: Enable marks valid transmit data, error flags faults; receive valid marks clean data.
// R11: In half duplex collision asserts when a collision occurs during transmission.
// R12: A partner MAC may tie its receive error input low in PHY role.
// R13: A partner PHY may tie its transmit error input low in MAC role.
// R14: Reduced-gigabit mode moves data on both clock edges at 125 MHz.
// R15: Register writes to mode, speed and delays override values sampled from straps.
module uplink_port_cfg (
  // Core clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // Strap pins
  input wire logic [1:0] I_INTERFACE_SELECT_STRAP,
  input wire logic I_SPEED_SELECT_STRAP,
  input wire logic I_MAC_PHY_ROLE_STRAP,
  // Link clock
  input wire logic I_LINK_CLK,
  // Transmit-side pins
  input wire logic I_PORT_TX_ENABLE,
  input wire logic I_PORT_TX_ERROR,
  input wire logic [3:0] I_PORT_TX_DATA,
  // Receive-side pins
  output logic O_PORT_RX_VALID,
  output logic O_PORT_RX_ERROR,
  output logic [3:0] O_PORT_RX_DATA,
  output logic O_PORT_RX_CTL_FALL,
  output logic [3:0] O_PORT_RX_DATA_FALL,
  // Two-way media status pins
  input wire logic I_PORT_COLLISION,
  output logic O_PORT_COLLISION,
  output logic O_PORT_COLLISION_OE,
  input wire logic I_PORT_CARRIER_SENSE,
  output logic O_PORT_CARRIER_SENSE,
  output logic O_PORT_CARRIER_SENSE_OE,
  // Two-way clock pins, input half is the link clock
  output logic O_PORT_TX_CLOCK,
  output logic O_PORT_TX_CLOCK_OE,
  output logic O_PORT_RX_CLOCK,
  output logic O_PORT_RX_CLOCK_OE,
  output logic O_GIG_EGRESS_CLOCK,
  // Pad delay controls
  output logic O_INGRESS_DELAY_EN,
  output logic O_EGRESS_DELAY_EN,
  // Switch side, on the link clock
  input wire logic I_FRAME_TX_VALID,
  input wire logic I_FRAME_TX_ERROR,
  input wire logic [7:0] I_FRAME_TX_DATA,
  input wire logic I_FRAME_COLLISION,
  input wire logic I_FRAME_CARRIER,
  output logic O_FRAME_RX_VALID,
  output logic O_FRAME_RX_ERROR,
  output logic [7:0] O_FRAME_RX_DATA,
  output logic O_LINK_COLLISION,
  output logic O_LINK_CARRIER
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic [1:0] ifsel_meta_r;
  logic [1:0] ifsel_sync_r;
  logic speed_meta_r;
  logic speed_sync_r;
  logic role_meta_r;
  logic role_sync_r;
  logic loaded_r;
  logic role_r;
  logic [7:0] ctrl_r;
  logic [31:0] prdata_r;
  logic oe_r;
  logic clk_div_r;
  logic [3:0] div_cnt_r;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic ctrl_wr;
  logic rgmii;
  logic phy_mii;
  logic [7:0] status;
  uplink_cfg_pkg::cfg_t cfg_core;
  uplink_cfg_pkg::cfg_t cfg_meta_r;
  uplink_cfg_pkg::cfg_t cfg_link_r;
  logic rst_link_meta_r;
  logic rst_link_r;
  uplink_cfg_pkg::nibble_t pin_in;
  uplink_cfg_pkg::nibble_t pin_rise;
  uplink_cfg_pkg::nibble_t pin_fall;
  uplink_cfg_pkg::frame_t frame_tx;
  uplink_cfg_pkg::frame_t frame_rx;

  // Whether an address is the byte address of a register index.
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] idx);
    addr_hit = (addr == {idx[9:0], 2'h0});
  endfunction

  // ******************************************************************
  // Strap synchronisers
  // ******************************************************************
  // Straps are held through reset, so the pair is settled when reset lifts.
  always_ff @(posedge I_CORE_CLK)
  begin
    ifsel_meta_r <= I_INTERFACE_SELECT_STRAP;
    ifsel_sync_r <= ifsel_meta_r;
    speed_meta_r <= I_SPEED_SELECT_STRAP;
    speed_sync_r <= speed_meta_r;
    role_meta_r <= I_MAC_PHY_ROLE_STRAP;
    role_sync_r <= role_meta_r;
  end

  // ******************************************************************
  // APB decode
  // ******************************************************************
  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE;
  assign hit_ctrl = addr_hit(I_PADDR, uplink_cfg_pkg::CTRL_IDX);
  assign hit_status = addr_hit(I_PADDR, uplink_cfg_pkg::STATUS_IDX);
  assign ctrl_wr = access && I_PWRITE && hit_ctrl;
  assign O_PREADY = access;
  assign O_PSLVERR = access && !hit_ctrl && !hit_status;
  assign O_PRDATA = prdata_r;

  // ******************************************************************
  // Control register and strap capture
  // ******************************************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      loaded_r <= 1'b0;
    else
      loaded_r <= 1'b1;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      ctrl_r <= uplink_cfg_pkg::CTRL_RESET; // R1 R2 R4 R5
    else if (ctrl_wr)
      ctrl_r <= I_PWDATA[7:0] & uplink_cfg_pkg::CTRL_WMASK; // R15
    else if (!loaded_r)
    begin
      ctrl_r[uplink_cfg_pkg::IFSEL_LSB +: 2] <= ifsel_sync_r; // R4
      ctrl_r[uplink_cfg_pkg::BIT_SPEED] <= speed_sync_r; // R5
    end
  end

  // The role has no register copy; it follows the strap taken at reset release.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      role_r <= 1'b0;
    else if (!loaded_r)
      role_r <= role_sync_r; // R6
  end

  // ******************************************************************
  // Read data
  // ******************************************************************
  // Read data is registered in the setup phase so the access phase needs no wait.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      prdata_r <= 32'h00000000;
    else if (setup && hit_ctrl)
      prdata_r <= {24'h000000, ctrl_r};
    else if (setup && hit_status)
      prdata_r <= {24'h000000, status};
    else if (setup)
      prdata_r <= 32'h00000000;
  end

  // ******************************************************************
  // Mode decode and pin direction
  // ******************************************************************
  assign rgmii = (ctrl_r[uplink_cfg_pkg::IFSEL_LSB +: 2] == uplink_cfg_pkg::IFSEL_RGMII); // R4
  assign phy_mii = role_r && !rgmii; // R6
  assign cfg_core.rgmii = rgmii;
  assign cfg_core.gig = rgmii && ctrl_r[uplink_cfg_pkg::BIT_SPEED]; // R5
  assign cfg_core.phy_role = role_r;
  assign status = {5'h00, cfg_core.gig, rgmii, role_r};

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      oe_r <= 1'b0;
    else
      oe_r <= phy_mii; // R7 R8
  end

  assign O_PORT_TX_CLOCK_OE = oe_r;
  assign O_PORT_RX_CLOCK_OE = oe_r;
  assign O_PORT_COLLISION_OE = oe_r;
  assign O_PORT_CARRIER_SENSE_OE = oe_r;
  assign O_INGRESS_DELAY_EN = ctrl_r[uplink_cfg_pkg::BIT_IN_DLY]; // R1
  assign O_EGRESS_DELAY_EN = ctrl_r[uplink_cfg_pkg::BIT_EG_DLY]; // R2
  // The forwarded clock is delayed in the pad, not in logic.
  assign O_GIG_EGRESS_CLOCK = I_LINK_CLK;

  // ******************************************************************
  // Nibble clock divider
  // ******************************************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST || !phy_mii)
    begin
      div_cnt_r <= 4'h0;
      clk_div_r <= 1'b0;
    end
    else if (div_cnt_r == 4'(uplink_cfg_pkg::MII_HALF_CYCLES - 1))
    begin
      div_cnt_r <= 4'h0;
      clk_div_r <= !clk_div_r; // R9
    end
    else
      div_cnt_r <= div_cnt_r + 4'h1;
  end

  assign O_PORT_TX_CLOCK = clk_div_r;
  assign O_PORT_RX_CLOCK = clk_div_r;

  // ******************************************************************
  // Crossing into the link domain
  // ******************************************************************
  // Configuration is quasi-static, so a level synchroniser per bit suffices.
  always_ff @(posedge I_LINK_CLK)
  begin
    rst_link_meta_r <= I_RST;
    rst_link_r <= rst_link_meta_r;
    cfg_meta_r <= cfg_core;
    cfg_link_r <= cfg_meta_r;
  end

  assign pin_in = {I_PORT_TX_ENABLE, I_PORT_TX_ERROR, I_PORT_TX_DATA};
  assign frame_tx = {I_FRAME_TX_VALID, I_FRAME_TX_ERROR, I_FRAME_TX_DATA};

  uplink_nibble_path u_path (
    .i_clk(I_LINK_CLK),
    .i_rst(rst_link_r),
    .i_cfg(cfg_link_r),
    .i_pin(pin_in),
    .i_pin_col(I_PORT_COLLISION),
    .i_pin_crs(I_PORT_CARRIER_SENSE),
    .i_frame_tx(frame_tx),
    .i_frame_col(I_FRAME_COLLISION),
    .i_frame_crs(I_FRAME_CARRIER),
    .o_pin_rise(pin_rise),
    .o_pin_fall(pin_fall),
    .o_col(O_PORT_COLLISION),
    .o_crs(O_PORT_CARRIER_SENSE),
    .o_frame_rx(frame_rx),
    .o_link_col(O_LINK_COLLISION),
    .o_link_crs(O_LINK_CARRIER)
  );

  assign O_PORT_RX_VALID = pin_rise.en; // R7 R8
  assign O_PORT_RX_ERROR = pin_rise.err;
  assign O_PORT_RX_DATA = pin_rise.data;
  assign O_PORT_RX_CTL_FALL = pin_fall.en;
  assign O_PORT_RX_DATA_FALL = pin_fall.data;
  assign O_FRAME_RX_VALID = frame_rx.valid;
  assign O_FRAME_RX_ERROR = frame_rx.err;
  assign O_FRAME_RX_DATA = frame_rx.data;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  chk_delay_reset: assert property ($fell(I_RST) |-> O_EGRESS_DELAY_EN && !O_INGRESS_DELAY_EN) // R1 R2
    else $error("delay controls not at reset values");
  chk_ingress_write: assert property (ctrl_wr |=> O_INGRESS_DELAY_EN == $past(I_PWDATA[4])) // R1
    else $error("ingress delay does not follow write");
  chk_egress_write: assert property (ctrl_wr |=> O_EGRESS_DELAY_EN == $past(I_PWDATA[3])) // R2
    else $error("egress delay does not follow write");
  chk_strap_load: assert property ($fell(I_RST) && !ctrl_wr |=> // R4 R5 R6
    ctrl_r[1:0] == $past(ifsel_sync_r) && ctrl_r[6] == $past(speed_sync_r) && role_r == $past(role_sync_r))
    else $error("straps not captured at reset release");
  chk_write_wins: assert property ($fell(I_RST) && ctrl_wr |=> // R15
    ctrl_r == ($past(I_PWDATA[7:0]) & 8'hDB))
    else $error("strap overrode register write");
  chk_gig_status: assert property (ctrl_wr && I_PWDATA[1:0] == 2'h3 && I_PWDATA[6] |=> // R4 R5
    cfg_core.gig && status[2])
    else $error("gigabit mode not selected");
  chk_pin_dir: assert property (phy_mii ##1 phy_mii |-> O_PORT_TX_CLOCK_OE && O_PORT_COLLISION_OE) // R7
    else $error("PHY role pins not driven");
  chk_mac_dir: assert property (!phy_mii |=> !O_PORT_RX_CLOCK_OE && !O_PORT_CARRIER_SENSE_OE) // R8
    else $error("MAC role pins driven");
  // A stretched or shortened half period would break the partner's nibble timing.
  chk_clock_half: assert property (phy_mii && $changed(clk_div_r) |=> // R9
    (!phy_mii || $stable(clk_div_r)) [*3] ##1 (!phy_mii || $changed(clk_div_r)))
    else $error("nibble clock half period wrong");
  chk_unmapped: assert property (access && !hit_ctrl && !hit_status |-> O_PSLVERR && O_PREADY)
    else $error("unmapped access not flagged");

  // ******************************************************************
  // Register, mode, clock and pin-direction checks
  // ******************************************************************
  // Once the straps are taken, only a bus write may move the control byte.
  chk_strap_ignored: assert property (loaded_r && !ctrl_wr |=> $stable(ctrl_r)) // R15
    else $error("control byte changed without a write");
  chk_role_hold: assert property (loaded_r |=> $stable(role_r)) // R6
    else $error("role changed after reset release");
  chk_nibble_select: assert property (ctrl_wr && I_PWDATA[1:0] != 2'h3 |=> !rgmii && !cfg_core.gig) // R4
    else $error("nibble mode not selected");
  chk_speed_low: assert property (ctrl_wr && I_PWDATA[1:0] == 2'h3 && !I_PWDATA[6] |=> rgmii && !cfg_core.gig) // R5
    else $error("low speed not selected");
  chk_clock_idle: assert property (!phy_mii |=> !O_PORT_TX_CLOCK && !O_PORT_RX_CLOCK) // R9
    else $error("nibble clock runs outside PHY role");
  chk_carrier_dir: assert property (phy_mii ##1 phy_mii |-> O_PORT_CARRIER_SENSE_OE && O_PORT_RX_CLOCK_OE) // R7
    else $error("PHY role carrier or clock not driven");
  // Status is read-only; a write there must leave the settings alone.
  chk_status_ignored: assert property (access && I_PWRITE && hit_status |=> $stable(ctrl_r))
    else $error("status write changed control byte");
  chk_unmapped_read: assert property (access && !hit_ctrl && !hit_status |-> O_PRDATA == 32'h00000000)
    else $error("unmapped read returned data");

  cov_rgmii_write: cover property (ctrl_wr && I_PWDATA[1:0] == 2'h3);
  cov_phy_role: cover property (phy_mii [*8]);
  cov_status_read: cover property (access && !I_PWRITE && hit_status);

endmodule
`default_nettype wire

// >>> testbench/ext_nibble_partner.sv
// Behavioural model of the external MAC or PHY facing the uplink port.
`timescale 1ns/10ps
`default_nettype none

module ext_nibble_partner (
  // Link clock and commands from the bench
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic i_err,
  input wire logic [3:0] i_nib,
  input wire logic [1:0] i_dev_dly,
  // Pins toward the device
  output logic o_en = 1'b0,
  output logic o_er = 1'b0,
  output logic [3:0] o_data = 4'h0,
  output logic o_col,
  output logic o_crs,
  output logic [1:0] o_dly
);
  // ******************************************************************
  // Transmit pins
  // ******************************************************************
  // Released data keep changing, so a stale nibble can never pass for a valid one.
  always @(posedge i_clk)
  begin
    o_en <= i_send;
    o_er <= i_send & i_err;
    o_data <= i_send ? i_nib : ~o_data;
  end
  // The partner shows carrier while it sends and never a collision; in PHY role the device's drive wins.
  assign o_col = 1'b0;
  assign o_crs = i_send;
  // Each clock direction is delayed opposite to the device.
  assign o_dly = ~i_dev_dly;
endmodule

`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the uplink port interface configuration block.
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ******************************************************************
  // Signals
  // ******************************************************************
  localparam logic [11:0] CTRL_A = {uplink_cfg_pkg::CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] STAT_A = {uplink_cfg_pkg::STATUS_IDX[9:0], 2'b00};
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] rd;
    logic [2:0] sts;
    logic in_d;
    logic eg_d;
    logic oe;
  } row_t;
  row_t rows [6] = '{'{8'h4B, 8'h4B, 3'h7, 1'b0, 1'b1, 1'b0}, '{8'h5B, 8'h5B, 3'h7, 1'b1, 1'b1, 1'b0},
    '{8'h53, 8'h53, 3'h7, 1'b1, 1'b0, 1'b0}, '{8'h03, 8'h03, 3'h3, 1'b0, 1'b0, 1'b0},
    '{8'hFF, 8'hDB, 3'h7, 1'b1, 1'b1, 1'b0}, '{8'h40, 8'h40, 3'h1, 1'b0, 1'b0, 1'b1}};
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic er, send = 1'b0, serr = 1'b0, tx_en, tx_er, p_col, p_crs, col_o, col_oe, crs_o, crs_oe;
  logic [3:0] snib = 4'h0, tx_d, rx_d, rx_df;
  logic [1:0] pdly;
  logic rx_v, rx_e, rx_cf, txc, txc_oe, rxc, rxc_oe, gclk, in_dly, eg_dly;
  logic f_v = 1'b0, f_e = 1'b0, f_col = 1'b0, f_crs = 1'b0, fr_v, fr_e, l_col, l_crs;
  logic [7:0] f_d = 8'h00, fr_d;
  int num_errors = 0, cmp_count = 0, n;
  wire logic pin_col = col_oe ? col_o : p_col;
  wire logic pin_crs = crs_oe ? crs_o : p_crs;

  always #5 clk = ~clk;
  initial
  begin
    #3;
    forever #40 lclk = ~lclk;
  end

  uplink_port_cfg dut (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
    .I_INTERFACE_SELECT_STRAP(2'h3), .I_SPEED_SELECT_STRAP(1'b1), .I_MAC_PHY_ROLE_STRAP(1'b1),
    .I_LINK_CLK(lclk), .I_PORT_TX_ENABLE(tx_en), .I_PORT_TX_ERROR(tx_er), .I_PORT_TX_DATA(tx_d),
    .O_PORT_RX_VALID(rx_v), .O_PORT_RX_ERROR(rx_e), .O_PORT_RX_DATA(rx_d), .O_PORT_RX_CTL_FALL(rx_cf),
    .O_PORT_RX_DATA_FALL(rx_df), .I_PORT_COLLISION(pin_col), .O_PORT_COLLISION(col_o),
    .O_PORT_COLLISION_OE(col_oe), .I_PORT_CARRIER_SENSE(pin_crs), .O_PORT_CARRIER_SENSE(crs_o),
    .O_PORT_CARRIER_SENSE_OE(crs_oe), .O_PORT_TX_CLOCK(txc), .O_PORT_TX_CLOCK_OE(txc_oe),
    .O_PORT_RX_CLOCK(rxc), .O_PORT_RX_CLOCK_OE(rxc_oe), .O_GIG_EGRESS_CLOCK(gclk),
    .O_INGRESS_DELAY_EN(in_dly), .O_EGRESS_DELAY_EN(eg_dly), .I_FRAME_TX_VALID(f_v),
    .I_FRAME_TX_ERROR(f_e), .I_FRAME_TX_DATA(f_d), .I_FRAME_COLLISION(f_col), .I_FRAME_CARRIER(f_crs),
    .O_FRAME_RX_VALID(fr_v), .O_FRAME_RX_ERROR(fr_e), .O_FRAME_RX_DATA(fr_d), .O_LINK_COLLISION(l_col),
    .O_LINK_CARRIER(l_crs));

  ext_nibble_partner partner (.i_clk(lclk), .i_send(send), .i_err(serr), .i_nib(snib),
    .i_dev_dly({in_dly, eg_dly}), .o_en(tx_en), .o_er(tx_er), .o_data(tx_d), .o_col(p_col),
    .o_crs(p_crs), .o_dly(pdly));

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // The request stands until pready is seen high at a rising edge; the answer is taken there, then released.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic lw(input int k);
    repeat (k) @(posedge lclk);
    #2;
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    // The link side needs its reset seen on several link edges, so reset spans link cycles.
    repeat (5) @(posedge lclk);
    chk(in_dly, 1'b0);
    chk(eg_dly, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, CTRL_A, {24'h0, rows[i].wd});
      apb(1'b0, CTRL_A, 32'h0);
      chk(rd, {24'h0, rows[i].rd});
      apb(1'b0, STAT_A, 32'h0);
      chk(rd, {29'h0, rows[i].sts});
      chk(in_dly, rows[i].in_d);
      chk(eg_dly, rows[i].eg_d);
      chk({col_oe, crs_oe, txc_oe, rxc_oe}, {4{rows[i].oe}});
      chk(pdly, {~rows[i].in_d, ~rows[i].eg_d});
    end
    apb(1'b0, 12'h000, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, STAT_A, 32'h0);
    chk(er, 1'b0);
    apb(1'b0, STAT_A, 32'h0);
    chk(rd, 32'h1);
    n = 0;
    rd[0] = txc;
    repeat (160)
    begin
      @(posedge clk);
      #1;
      if (txc !== rd[0])
        n++;
      rd[0] = txc;
    end
    chk(n, 40);
    chk({rxc_oe, rxc}, {1'b1, txc});
    lw(4);
    send <= 1'b1;
    snib <= 4'h5;
    f_v <= 1'b1;
    f_d <= 8'h0C;
    f_col <= 1'b1;
    f_crs <= 1'b1;
    lw(5);
    chk({fr_v, fr_e, fr_d}, {1'b1, 1'b0, 8'h05});
    chk({rx_v, rx_e, rx_d}, {1'b1, 1'b0, 4'hC});
    chk({col_o, crs_o}, 2'b11);
    serr <= 1'b1;
    f_col <= 1'b0;
    lw(5);
    chk(fr_e, 1'b1);
    chk(col_o, 1'b0);
    apb(1'b1, CTRL_A, 32'h4B);
    lw(8);
    f_d <= 8'hA3;
    lw(5);
    chk({rx_v, rx_d, rx_df, rx_cf}, {1'b1, 4'h3, 4'hA, 1'b1});
    chk({col_oe, col_o, crs_o}, 3'b000);
    chk(gclk, lclk);
    chk({l_col, l_crs}, 2'b01);
    apb(1'b1, CTRL_A, 32'h10);
    @(posedge clk);
    chk({in_dly, eg_dly}, 2'b10);
    rst <= 1'b1;
    repeat (4) @(posedge lclk);
    chk({in_dly, eg_dly}, 2'b01);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'h4B);
    end_sim();
  end
endmodule

`default_nettype wire
